/* File: design/rlr_exec_map.vh */
// Constants for the return-with-literal and rotate execution datapath
`ifndef RLR_EXEC_MAP_VH
`define RLR_EXEC_MAP_VH
// ----------------------------------------
// Opcode encodings on the decoder port
// ----------------------------------------
`define RLR_OP_NONE 2'h0
`define RLR_OP_RET_LIT 2'h1
`define RLR_OP_ROT_LEFT 2'h2
`define RLR_OP_ROT_RIGHT 2'h3
// ----------------------------------------
// Destination select values
// ----------------------------------------
`define RLR_DEST_WORK 1'h0
`define RLR_DEST_FILE 1'h1
// ----------------------------------------
// Reset values, timing counts and file address width
// ----------------------------------------
`define RLR_WORK_RESET 8'h00
`define RLR_CARRY_RESET 1'h0
`define RLR_PC_RESET 15'h0000
`define RLR_RET_CYCLES 2'h2
`define RLR_FILE_ADDR_MSB 6
`endif

/* File: design/rlr_file_mem.v */
// Small file register memory with registered read data
`timescale 1ns/1ps
module rlr_file_mem #(
	parameter AW = 7,
	parameter DW = 8
) (
	input wire clk,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

/* File: design/rlr_exec.v */
// Execution datapath for return-with-literal and the two carry rotates
`timescale 1ns/1ps
`include "rlr_exec_map.vh"
module rlr_exec #(
	parameter AW = 7,
	parameter PCW = 15
) (
	input wire clk,
	input wire rst,
	input wire op_valid,
	input wire [1:0] op_code,
	input wire [7:0] op_literal,
	input wire [AW-1:0] op_file_addr,
	input wire op_dest,
	input wire [PCW-1:0] stack_top_entry,
	input wire host_file_wr,
	input wire [AW-1:0] host_file_addr,
	input wire [7:0] host_file_data,
	output reg op_ready,
	output reg op_done,
	output reg [7:0] work_reg,
	output reg carry_flag,
	output reg [PCW-1:0] pc,
	output reg stack_pop,
	output reg file_wr,
	output reg [AW-1:0] file_wr_addr,
	output reg [7:0] file_wr_data
);
	// ----------------------------------------
	// State machine
	// ----------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_READ = 2'h1;
	localparam ST_RET2 = 2'h2;
	reg [1:0] state;
	reg [1:0] op_hold;
	reg dest_hold;
	reg [AW-1:0] addr_hold;
	wire [7:0] mem_rd;
	reg fwd_hit;
	reg [7:0] fwd_data;
	wire [7:0] rot_src;
	wire [7:0] rot_left;
	wire [7:0] rot_right;
	reg mem_wr;
	reg [AW-1:0] mem_addr;
	reg [7:0] mem_data;
	reg [7:0] next_value;
	reg next_carry;
	// Outside writes share the port; an executing rotate wins
	always @* begin
		mem_wr = host_file_wr;
		mem_addr = host_file_addr;
		mem_data = host_file_data;
		if (file_wr) begin
			mem_wr = 1'b1;
			mem_addr = file_wr_addr;
			mem_data = file_wr_data;
		end
	end
	rlr_file_mem #(.AW(AW), .DW(8)) u_mem (
		.clk(clk),
		.wr_en(mem_wr),
		.wr_addr(mem_addr),
		.wr_data(mem_data),
		.rd_addr(op_file_addr),
		.rd_data(mem_rd)
	);
	// ----------------------------------------
	// Rotate through carry
	// ----------------------------------------
	// ----------------------------------------
	// Write forwarding
	// ----------------------------------------
	// A write landing on the accept edge is missed by the registered read
	assign rot_src = fwd_hit ? fwd_data : mem_rd;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_rot
			if (gi == 0) begin : g_lsb
				assign rot_left[gi] = carry_flag;
				assign rot_right[gi] = rot_src[gi + 1];
			end else if (gi == 7) begin : g_msb
				assign rot_left[gi] = rot_src[gi - 1];
				assign rot_right[gi] = carry_flag;
			end else begin : g_mid
				assign rot_left[gi] = rot_src[gi - 1];
				assign rot_right[gi] = rot_src[gi + 1];
			end
		end
	endgenerate
	always @* begin
		if (op_hold == `RLR_OP_ROT_LEFT) begin
			next_value = rot_left;
			next_carry = rot_src[7];
		end else begin
			next_value = rot_right;
			next_carry = rot_src[0];
		end
	end
	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			op_hold <= `RLR_OP_NONE;
			dest_hold <= `RLR_DEST_WORK;
			addr_hold <= {AW{1'b0}};
			fwd_hit <= 1'b0;
			fwd_data <= 8'h00;
			op_ready <= 1'b1;
			op_done <= 1'b0;
			work_reg <= `RLR_WORK_RESET;
			carry_flag <= `RLR_CARRY_RESET;
			pc <= `RLR_PC_RESET;
			stack_pop <= 1'b0;
			file_wr <= 1'b0;
			file_wr_addr <= {AW{1'b0}};
			file_wr_data <= 8'h00;
		end else begin
			op_done <= 1'b0;
			stack_pop <= 1'b0;
			file_wr <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (op_valid && op_code != `RLR_OP_NONE) begin
					op_hold <= op_code;
					dest_hold <= op_dest;
					addr_hold <= op_file_addr;
					fwd_hit <= mem_wr && (mem_addr == op_file_addr);
					fwd_data <= mem_data;
					op_ready <= 1'b0;
					if (op_code == `RLR_OP_RET_LIT) begin
						// Flags untouched on the return path
						work_reg <= op_literal;
						pc <= stack_top_entry;
						stack_pop <= 1'b1;
						state <= ST_RET2;
					end else begin
						// Memory read is registered, so wait one cycle
						state <= ST_READ;
					end
				end
			end
			ST_READ: begin
				carry_flag <= next_carry;
				if (dest_hold == `RLR_DEST_WORK) begin
					work_reg <= next_value;
				end else begin
					file_wr <= 1'b1;
					file_wr_addr <= addr_hold;
					file_wr_data <= next_value;
				end
				op_done <= 1'b1;
				op_ready <= 1'b1;
				state <= ST_IDLE;
			end
			ST_RET2: begin
				// Second cycle: pipeline flush slot
				op_done <= 1'b1;
				op_ready <= 1'b1;
				state <= ST_IDLE;
			end
			default: begin
				op_ready <= 1'b1;
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

/* File: verif/rlr_exec_assertions.sv */
// Checker for the return and rotate datapath ports
`timescale 1ns/1ps
module rlr_exec_assertions (
	input wire clk,
	input wire rst,
	input wire op_valid,
	input wire op_ready,
	input wire op_dest,
	input wire op_done,
	input wire carry_flag,
	input wire stack_pop,
	input wire file_wr,
	input wire [1:0] op_code,
	input wire [7:0] op_literal,
	input wire [7:0] work_reg,
	input wire [14:0] stack_top_entry,
	input wire [14:0] pc
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire ret = op_valid && op_ready && op_code == 2'h1;
	wire r0 = op_valid && op_ready && op_code[1] && !op_dest;
	wire r1 = op_valid && op_ready && op_code[1] && op_dest;
	property p_lit; ret |=> work_reg == $past(op_literal); endproperty
	a_lit: assert property (p_lit) else $error("lit");
	property p_flg; ret |=> $stable(carry_flag) [*2]; endproperty
	a_flg: assert property (p_flg) else $error("flag");
	property p_pc; ret |=> pc == $past(stack_top_entry); endproperty
	a_pc: assert property (p_pc) else $error("pc");
	property p_two; ret |=> !op_done ##1 op_done; endproperty
	a_two: assert property (p_two) else $error("two");
	property p_pop; ret |=> stack_pop ##1 !stack_pop; endproperty
	a_pop: assert property (p_pop) else $error("pop");
	property p_d1; r1 |=> ##1 file_wr && $stable(work_reg); endproperty
	a_d1: assert property (p_d1) else $error("dest");
	property p_rl; r0 && !op_code[0] |=> ##1 !file_wr && work_reg[0] == $past(carry_flag); endproperty
	a_rl: assert property (p_rl) else $error("left");
	property p_rr; r0 && op_code[0] |=> ##1 !file_wr && work_reg[7] == $past(carry_flag); endproperty
	a_rr: assert property (p_rr) else $error("right");
	cover property (ret);
	cover property (r0);
	cover property (r1);
endmodule
bind rlr_exec rlr_exec_assertions i_chk (
	.clk(clk),
	.rst(rst),
	.op_valid(op_valid),
	.op_ready(op_ready),
	.op_dest(op_dest),
	.op_done(op_done),
	.carry_flag(carry_flag),
	.stack_pop(stack_pop),
	.file_wr(file_wr),
	.op_code(op_code),
	.op_literal(op_literal),
	.work_reg(work_reg),
	.stack_top_entry(stack_top_entry),
	.pc(pc)
);

/* File: verif/rlr_stack_model.sv */
// Return stack model: top entry out, pop on request
`timescale 1ns/1ps
module rlr_stack_model (
	input wire clk,
	input wire stack_pop,
	output wire [14:0] stack_top_entry
);
	reg [2:0] sp = 3'h7;
	// Entry is 0x1000 plus index, so each pop shows a new value
	assign stack_top_entry = {12'h200, sp};
	always @(posedge clk) if (stack_pop) sp <= sp - 3'h1;
endmodule

/* File: verif/rlr_exec_tb.sv */
// Testbench for the return and rotate datapath
`timescale 1ns/1ps
module rlr_exec_tb;
	reg clk = 1'h0, rst = 1'h1, op_valid = 1'h0, op_dest = 1'h0, host_file_wr = 1'h0;
	reg [1:0] op_code = 2'h0;
	reg [7:0] op_literal = 8'h00, host_file_data = 8'he6;
	reg [6:0] op_file_addr = 7'h7f, host_file_addr = 7'h7f;
	wire op_ready, op_done, carry_flag, stack_pop, file_wr;
	wire [7:0] work_reg, file_wr_data;
	wire [6:0] file_wr_addr;
	wire [14:0] pc, stack_top_entry;
	integer miscompares = 0, checked = 0;
	rlr_exec i_rlr_exec (
		.clk(clk),
		.rst(rst),
		.op_valid(op_valid),
		.op_code(op_code),
		.op_literal(op_literal),
		.op_file_addr(op_file_addr),
		.op_dest(op_dest),
		.stack_top_entry(stack_top_entry),
		.host_file_wr(host_file_wr),
		.host_file_addr(host_file_addr),
		.host_file_data(host_file_data),
		.op_ready(op_ready),
		.op_done(op_done),
		.work_reg(work_reg),
		.carry_flag(carry_flag),
		.pc(pc),
		.stack_pop(stack_pop),
		.file_wr(file_wr),
		.file_wr_addr(file_wr_addr),
		.file_wr_data(file_wr_data)
	);
	rlr_stack_model i_rlr_stack_model (
		.clk(clk),
		.stack_pop(stack_pop),
		.stack_top_entry(stack_top_entry)
	);
	initial forever #10 clk = ~clk;
	task chk(input [31:0] got, input [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Gap cycle after each op lets a file write land before the next read
	task run(input [1:0] c, input [7:0] k, input d);
		{op_code, op_literal, op_dest, op_valid} = {c, k, d, 1'h1};
		@(negedge clk) op_valid = 1'h0;
		chk(op_ready, 1'h0);
		chk(stack_pop, c == 2'h1);
		@(negedge clk);
		chk(op_done, 1'h1);
		chk(file_wr, c[1] & d);
		@(negedge clk);
		chk(op_done, 1'h0);
		@(negedge clk);
	endtask
	task t_rotate;
		run(2'h2, 8'h00, 1'h0);
		chk({carry_flag, work_reg}, 9'h1cc);
		run(2'h3, 8'h00, 1'h1);
		chk({carry_flag, work_reg}, 9'h0cc);
		chk(file_wr_data, 8'hf3);
		chk(file_wr_addr, 7'h7f);
		run(2'h3, 8'h00, 1'h0);
		chk({carry_flag, work_reg}, 9'h179);
		$display("rotate test done");
	endtask
	// Second rotate is taken on the edge where the first one's file write lands
	task t_back;
		{op_code, op_dest, op_valid} = {2'h2, 1'h1, 1'h1};
		@(negedge clk) {op_code, op_dest} = {2'h3, 1'h0};
		repeat (2) @(negedge clk);
		op_valid = 1'h0;
		repeat (2) @(negedge clk);
		chk(file_wr_data, 8'he7);
		chk({carry_flag, work_reg}, 9'h1f3);
		$display("back to back test done");
	endtask
	task t_return;
		run(2'h1, 8'hff, 1'h0);
		chk({carry_flag, work_reg}, 9'h1ff);
		chk(pc, 15'h1007);
		run(2'h1, 8'h00, 1'h0);
		chk({pc, work_reg}, 23'h100600);
		$display("return test done");
	endtask
	task stop_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'h0;
		host_file_wr = 1'h1;
		@(negedge clk) host_file_wr = 1'h0;
		t_rotate;
		t_back;
		t_return;
		stop_test;
	end
	initial begin
		#20000;
		miscompares = miscompares + 1;
		stop_test;
	end
endmodule
